// ==== hdl/system_bus_config_regs.sv ====
// System configuration and bus window control register bank.
// Assumes an Avalon-MM master on the same clock and synchronous pins.
`timescale 1ns/1ps
module system_bus_config_regs (
   input wire logic i_clock,
   input wire logic i_nrst,
   // Avalon-MM slave
   input wire logic [15:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic [1:0] o_response,
   // Reset straps and configuration inputs
   input wire logic i_external_access_pin,
   input wire logic [15:0] i_port_zero_pins,
   input wire logic i_data_bus_8bit,
   input wire logic i_end_of_init_instruction,
   // Pin muxing
   output logic o_system_clock_output_pin,
   output logic o_clock_pin_is_gpio,
   input wire logic i_byte_high_enable,
   output logic o_byte_high_enable_pin,
   output logic o_byte_high_pin_is_gpio,
   // Core address decode and stacking
   input wire logic [23:0] i_core_address,
   output logic o_rom_internal,
   output logic o_rom_external,
   output logic o_push_code_segment,
   output logic [10:0] o_stack_words,
   // External bus cycle
   input wire logic i_cycle_start,
   input wire logic [2:0] i_window_select,
   input wire logic i_ready,
   output logic o_cycle_end,
   output sysbus_cfg_pkg::bus_window_t o_boot_window
);

   sysbus_cfg_pkg::bus_window_t windows [0:4];
   sysbus_cfg_pkg::bus_window_t next_windows [0:4];
   sysbus_cfg_pkg::system_config_t sys_cfg;
   sysbus_cfg_pkg::system_config_t next_sys_cfg;
   logic init_done;
   logic next_init_done;
   logic strap_pending;
   logic next_strap_pending;
   logic [23:0] probe;
   logic [23:0] next_probe;
   logic access_done;
   logic next_access_done;
   logic [31:0] next_readdata;
   logic [1:0] next_response;
   logic [15:0] wdata;
   logic hit_rom;
   sysbus_cfg_pkg::bus_window_t active_window;

   ////////////////////////////////////////////////////////////////////////
   // Helpers shared by decode and register update
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] data, input logic [15:0] mask);
      merge16 = (old & ~mask) | (data & mask);
   endfunction

   // Same packing for every window register
   function automatic logic [15:0] pack_window(
      input sysbus_cfg_pkg::bus_window_t w);
      pack_window = {w.cs_write_enable, w.cs_read_enable, w.ready_polarity,
         w.ready_enable, 1'b0, w.bus_active, w.address_latch_control, 1'b0,
         w.bus_type, w.tristate_wait, w.read_write_delay,
         w.wait_state_count};
   endfunction

   function automatic sysbus_cfg_pkg::bus_window_t unpack_window(
      input logic [15:0] v);
      unpack_window.cs_write_enable = v[sysbus_cfg_pkg::BW_CS_WRITE_ENABLE];
      unpack_window.cs_read_enable = v[sysbus_cfg_pkg::BW_CS_READ_ENABLE];
      unpack_window.ready_polarity = v[sysbus_cfg_pkg::BW_READY_POLARITY];
      unpack_window.ready_enable = v[sysbus_cfg_pkg::BW_READY_ENABLE];
      unpack_window.bus_active = v[sysbus_cfg_pkg::BW_BUS_ACTIVE];
      unpack_window.address_latch_control =
         v[sysbus_cfg_pkg::BW_ADDRESS_LATCH];
      unpack_window.bus_type = v[sysbus_cfg_pkg::BW_BUS_TYPE_LSB +: 2];
      unpack_window.tristate_wait = v[sysbus_cfg_pkg::BW_TRISTATE_WAIT];
      unpack_window.read_write_delay =
         v[sysbus_cfg_pkg::BW_READ_WRITE_DELAY];
      unpack_window.wait_state_count =
         v[sysbus_cfg_pkg::BW_WAIT_COUNT_LSB +: 4];
   endfunction

   function automatic logic [15:0] pack_sys(
      input sysbus_cfg_pkg::system_config_t s);
      pack_sys = {s.stack_size, s.rom_segment_select, s.segmentation_disable,
         s.internal_rom_enable, s.byte_high_disable, s.clock_out_enable,
         8'h00};
   endfunction

   function automatic sysbus_cfg_pkg::system_config_t unpack_sys(
      input logic [15:0] v);
      unpack_sys.clock_out_enable = v[sysbus_cfg_pkg::SC_CLOCK_OUT_ENABLE];
      unpack_sys.byte_high_disable = v[sysbus_cfg_pkg::SC_BYTE_HIGH_DISABLE];
      unpack_sys.internal_rom_enable =
         v[sysbus_cfg_pkg::SC_INTERNAL_ROM_ENABLE];
      unpack_sys.segmentation_disable =
         v[sysbus_cfg_pkg::SC_SEGMENTATION_DISABLE];
      unpack_sys.rom_segment_select =
         v[sysbus_cfg_pkg::SC_ROM_SEGMENT_SELECT];
      unpack_sys.stack_size = v[sysbus_cfg_pkg::SC_STACK_SIZE_LSB +: 3];
   endfunction

   // Byte enables gate the low half lane by lane
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus side: waitrequest drops one cycle after the request appears
   assign o_waitrequest = (i_read | i_write) & ~access_done;
   assign wdata = i_writedata[15:0];

   // Next values: straps, lock, register reads and writes
   always_comb begin
      next_windows = windows;
      next_sys_cfg = sys_cfg;
      next_init_done = init_done;
      next_strap_pending = 1'b0;
      next_probe = probe;
      next_access_done = (i_read | i_write) & ~access_done;
      next_readdata = o_readdata;
      next_response = o_response;
      // Straps are taken on the first edge after reset release
      if (strap_pending) begin
         next_sys_cfg.internal_rom_enable = i_external_access_pin;
         next_windows[0] = unpack_window(merge16(pack_window(windows[0]),
            i_port_zero_pins, sysbus_cfg_pkg::BW0_STRAP_MASK));
         next_sys_cfg.byte_high_disable = i_data_bus_8bit;
      end
      if (i_end_of_init_instruction) begin
         next_init_done = 1'b1;
      end
      if ((i_read | i_write) & ~access_done) begin
         next_readdata = 32'h0000_0000;
         next_response = 2'b00;
         case (i_address)
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_0:
               next_readdata[15:0] = pack_window(windows[0]);
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_1:
               next_readdata[15:0] = pack_window(windows[1]);
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_2:
               next_readdata[15:0] = pack_window(windows[2]);
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_3:
               next_readdata[15:0] = pack_window(windows[3]);
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_4:
               next_readdata[15:0] = pack_window(windows[4]);
            sysbus_cfg_pkg::ADDR_SYSTEM_CONFIG:
               next_readdata[15:0] = pack_sys(sys_cfg);
            sysbus_cfg_pkg::ADDR_INIT_CONTROL:
               next_readdata[0] = init_done;
            sysbus_cfg_pkg::ADDR_STATUS: begin
               next_readdata[sysbus_cfg_pkg::ST_INIT_DONE] = init_done;
               next_readdata[sysbus_cfg_pkg::ST_BYTE_HIGH_PIN] =
                  ~sys_cfg.byte_high_disable;
               next_readdata[sysbus_cfg_pkg::ST_CLOCK_PIN] =
                  sys_cfg.clock_out_enable;
               next_readdata[sysbus_cfg_pkg::ST_ROM_HIT] = hit_rom;
            end
            sysbus_cfg_pkg::ADDR_ROM_PROBE:
               next_readdata[23:0] = probe;
            default: next_response = 2'b10; // Unmapped: slave error
         endcase
         if (!i_read) begin
            next_readdata = 32'h0000_0000;
         end
      end
      // Writes take effect once, at the cycle waitrequest is low
      if (i_write & access_done) begin
         case (i_address)
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_0:
               next_windows[0] = unpack_window(merge16(pack_window(windows[0]),
                  wdata, lane_mask(i_byteenable) &
                  sysbus_cfg_pkg::BW_WRITE_MASK));
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_1:
               next_windows[1] = unpack_window(merge16(pack_window(windows[1]),
                  wdata, lane_mask(i_byteenable) &
                  sysbus_cfg_pkg::BW_WRITE_MASK));
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_2:
               next_windows[2] = unpack_window(merge16(pack_window(windows[2]),
                  wdata, lane_mask(i_byteenable) &
                  sysbus_cfg_pkg::BW_WRITE_MASK));
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_3:
               next_windows[3] = unpack_window(merge16(pack_window(windows[3]),
                  wdata, lane_mask(i_byteenable) &
                  sysbus_cfg_pkg::BW_WRITE_MASK));
            sysbus_cfg_pkg::ADDR_BUS_WINDOW_CTRL_4:
               next_windows[4] = unpack_window(merge16(pack_window(windows[4]),
                  wdata, lane_mask(i_byteenable) &
                  sysbus_cfg_pkg::BW_WRITE_MASK));
            sysbus_cfg_pkg::ADDR_SYSTEM_CONFIG: begin
               if (!init_done) begin
                  next_sys_cfg = unpack_sys(merge16(pack_sys(sys_cfg), wdata,
                     lane_mask(i_byteenable) &
                     sysbus_cfg_pkg::SC_WRITE_MASK));
               end
            end
            sysbus_cfg_pkg::ADDR_ROM_PROBE:
               next_probe = i_writedata[23:0];
            default: next_probe = probe;
         endcase
      end
   end

   // Registers; the lock is held until the next reset
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int k = 0; k < 5; k++) begin
            windows[k] <= sysbus_cfg_pkg::bus_window_t'(
               sysbus_cfg_pkg::BW_RESET[13:0]);
         end
         sys_cfg <= sysbus_cfg_pkg::system_config_t'(8'h00);
         init_done <= 1'b0;
         strap_pending <= 1'b1;
         probe <= 24'h000000;
         access_done <= 1'b0;
         o_readdata <= 32'h0000_0000;
         o_response <= 2'b00;
      end else begin
         windows <= next_windows;
         sys_cfg <= next_sys_cfg;
         init_done <= next_init_done;
         strap_pending <= next_strap_pending;
         probe <= next_probe;
         access_done <= next_access_done;
         o_readdata <= next_readdata;
         o_response <= next_response;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin muxing; gating the clock here is a mux, not a clock tree
   assign o_system_clock_output_pin =
      sys_cfg.clock_out_enable & i_clock;
   assign o_clock_pin_is_gpio = ~sys_cfg.clock_out_enable;
   assign o_byte_high_enable_pin =
      ~sys_cfg.byte_high_disable & i_byte_high_enable;
   assign o_byte_high_pin_is_gpio = sys_cfg.byte_high_disable;

   // ROM area decode, 32 KB at segment zero or one
   function automatic logic in_rom(input logic [23:0] a, input logic seg1);
      logic [23:0] base;
      base = seg1 ? sysbus_cfg_pkg::ROM_BASE_SEG1 :
         sysbus_cfg_pkg::ROM_BASE_SEG0;
      in_rom = (a >= base) && (a < base + sysbus_cfg_pkg::ROM_SIZE);
   endfunction

   assign hit_rom =
      in_rom(i_core_address, sys_cfg.rom_segment_select);
   assign o_rom_internal = hit_rom & sys_cfg.internal_rom_enable;
   assign o_rom_external = hit_rom & ~sys_cfg.internal_rom_enable;

   // Stacking of the code segment pointer on trap entry and exit
   assign o_push_code_segment =
      ~sys_cfg.segmentation_disable;

   // Stack size: 32 words shifted left by the field, capped at 1024
   assign o_stack_words = (sys_cfg.stack_size >= 3'h5) ?
      sysbus_cfg_pkg::STACK_WORDS_MAX :
      11'(sysbus_cfg_pkg::STACK_WORDS_MIN << sys_cfg.stack_size);

   // Window zero steers the first fetch after reset
   assign o_boot_window = windows[0];
   // Selects above four fall back to window zero
   assign active_window = (i_window_select <= 3'h4) ?
      windows[i_window_select] : windows[0];

   bus_window_ready ready_wait (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_cycle_start(i_cycle_start),
      .i_window(active_window),
      .i_ready(i_ready),
      .o_cycle_end(o_cycle_end)
   );

endmodule

// ==== hdl/sysbus_cfg_pkg.sv ====
// Constants, field layouts and types for the system and bus window
// configuration register bank.
// Assumes a 16-bit register file reached over a 32-bit Avalon-MM slave.
package sysbus_cfg_pkg;

   // Byte addresses on the Avalon-MM slave
   localparam logic [15:0] ADDR_BUS_WINDOW_CTRL_0 = 16'hff0c;
   localparam logic [15:0] ADDR_BUS_WINDOW_CTRL_1 = 16'hff14;
   localparam logic [15:0] ADDR_BUS_WINDOW_CTRL_2 = 16'hff16;
   localparam logic [15:0] ADDR_BUS_WINDOW_CTRL_3 = 16'hff18;
   localparam logic [15:0] ADDR_BUS_WINDOW_CTRL_4 = 16'hff1a;
   localparam logic [15:0] ADDR_SYSTEM_CONFIG = 16'hff20;
   localparam logic [15:0] ADDR_INIT_CONTROL = 16'hff24;
   localparam logic [15:0] ADDR_STATUS = 16'hff28;
   localparam logic [15:0] ADDR_ROM_PROBE = 16'hff2c;

   // System configuration fields
   localparam int SC_CLOCK_OUT_ENABLE = 8;
   localparam int SC_BYTE_HIGH_DISABLE = 9;
   localparam int SC_INTERNAL_ROM_ENABLE = 10;
   localparam int SC_SEGMENTATION_DISABLE = 11;
   localparam int SC_ROM_SEGMENT_SELECT = 12;
   localparam int SC_STACK_SIZE_LSB = 13;
   localparam logic [15:0] SC_WRITE_MASK = 16'hff00;
   localparam logic [15:0] SC_RESET = 16'h0000;

   // Bus window control fields
   localparam int BW_CS_WRITE_ENABLE = 15;
   localparam int BW_CS_READ_ENABLE = 14;
   localparam int BW_READY_POLARITY = 13;
   localparam int BW_READY_ENABLE = 12;
   localparam int BW_BUS_ACTIVE = 10;
   localparam int BW_ADDRESS_LATCH = 9;
   localparam int BW_BUS_TYPE_LSB = 6;
   localparam int BW_TRISTATE_WAIT = 5;
   localparam int BW_READ_WRITE_DELAY = 4;
   localparam int BW_WAIT_COUNT_LSB = 0;
   localparam logic [15:0] BW_WRITE_MASK = 16'hf6ff;
   localparam logic [15:0] BW_RESET = 16'h0000;
   // Bits of window zero that the port-zero pins load on the first edge after reset release
   localparam logic [15:0] BW0_STRAP_MASK = 16'h06c0;

   // Status bits
   localparam int ST_INIT_DONE = 0;
   localparam int ST_BYTE_HIGH_PIN = 1;
   localparam int ST_CLOCK_PIN = 2;
   localparam int ST_ROM_HIT = 3;

   // ROM area decode
   localparam logic [23:0] ROM_BASE_SEG0 = 24'h000000;
   localparam logic [23:0] ROM_BASE_SEG1 = 24'h010000;
   localparam logic [23:0] ROM_SIZE = 24'h008000;
   // Stack size extremes in words
   localparam logic [10:0] STACK_WORDS_MIN = 11'h020;
   localparam logic [10:0] STACK_WORDS_MAX = 11'h400;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DATA = 2'b01,
      BUS_DONE = 2'b11
   } bus_state_t;

   typedef struct packed {
      logic cs_write_enable;
      logic cs_read_enable;
      logic ready_polarity;
      logic ready_enable;
      logic bus_active;
      logic address_latch_control;
      logic [1:0] bus_type;
      logic tristate_wait;
      logic read_write_delay;
      logic [3:0] wait_state_count;
   } bus_window_t;

   typedef struct packed {
      logic clock_out_enable;
      logic byte_high_disable;
      logic internal_rom_enable;
      logic segmentation_disable;
      logic rom_segment_select;
      logic [2:0] stack_size;
   } system_config_t;

endpackage

// ==== hdl/bus_window_ready.sv ====
// Ready wait logic for one external bus cycle.
// Assumes the ready input is already synchronous to the system clock.
`timescale 1ns/1ps
module bus_window_ready (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_cycle_start,
   input wire sysbus_cfg_pkg::bus_window_t i_window,
   input wire logic i_ready,
   output logic o_cycle_end
);

   sysbus_cfg_pkg::bus_state_t state;
   sysbus_cfg_pkg::bus_state_t next_state;
   logic ready_active;

   ////////////////////////////////////////////////////////////////////////
   // Ready level is compared against the selected polarity
   assign ready_active = (i_ready == i_window.ready_polarity);

   // Cycle waits in data phase until ready, when ready is enabled
   always_comb begin
      next_state = state;
      case (state)
         sysbus_cfg_pkg::BUS_IDLE: begin
            if (i_cycle_start) begin
               next_state = sysbus_cfg_pkg::BUS_DATA;
            end
         end
         sysbus_cfg_pkg::BUS_DATA: begin
            if (!i_window.ready_enable || ready_active) begin
               next_state = sysbus_cfg_pkg::BUS_DONE;
            end
         end
         sysbus_cfg_pkg::BUS_DONE: next_state = sysbus_cfg_pkg::BUS_IDLE;
         default: next_state = sysbus_cfg_pkg::BUS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= sysbus_cfg_pkg::BUS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign o_cycle_end = (state == sysbus_cfg_pkg::BUS_DONE);

endmodule

// ==== verif/sysbus_cfg_sva.sv ====
// Concurrent checks on the ports of the configuration register bank.
// Assumes one clock domain and the Avalon-MM timing of the bank.
`timescale 1ns/1ps
module sysbus_cfg_chk (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [15:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   input wire logic [1:0] o_response,
   input wire logic [15:0] i_port_zero_pins,
   input wire logic i_byte_high_enable,
   input wire logic o_byte_high_enable_pin,
   input wire logic o_byte_high_pin_is_gpio,
   input wire logic [23:0] i_core_address,
   input wire logic o_rom_internal,
   input wire logic o_rom_external,
   input wire logic [10:0] o_stack_words,
   input wire logic i_cycle_start,
   input wire logic [2:0] i_window_select,
   input wire logic i_ready,
   input wire logic o_cycle_end,
   input wire sysbus_cfg_pkg::bus_window_t o_boot_window
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   logic req;
   logic taken;
   logic win;
   logic mapped;
   ////////////////////////////////////////////////////////////////////////
   // Own decode, so a wrong design map cannot hide itself
   always_comb begin
      req = i_read | i_write;
      taken = i_read & ~o_waitrequest;
      win = i_address inside {16'hff0c, 16'hff14, 16'hff16, 16'hff18,
         16'hff1a};
      mapped = win || i_address inside {16'hff20, 16'hff24, 16'hff28,
         16'hff2c};
   end
   sequence s_req_new;
      req && !$past(req);
   endsequence
   sequence s_wait_then_go;
      o_waitrequest ##1 !o_waitrequest;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_wait_one: assert property (s_req_new |-> s_wait_then_go)
      else $error("waitrequest not low one cycle after request");
   chk_resp_code: assert property (taken |-> o_response ==
      (mapped ? 2'b00 : 2'b10)) else $error("wrong response code");
   chk_reserved_zero: assert property (taken && win |->
      o_readdata[11] == 1'b0 && o_readdata[8] == 1'b0 &&
      o_readdata[31:16] == 16'h0000) else $error("reserved bit set");
   chk_bhe_gate: assert property (o_byte_high_enable_pin ==
      (!o_byte_high_pin_is_gpio && i_byte_high_enable))
      else $error("byte high pin gating wrong");
   chk_rom_onehot: assert property (!(o_rom_internal &&
      o_rom_external)) else $error("rom internal and external");
   chk_rom_window: assert property (o_rom_internal |->
      i_core_address[23:15] inside {9'h000, 9'h002})
      else $error("internal rom outside its area");
   chk_stack_range: assert property (o_stack_words >= 11'h020 &&
      o_stack_words <= 11'h400) else $error("stack size out of range");
   chk_strap_load: assert property ($rose(i_nrst) |=>
      {o_boot_window.bus_active, o_boot_window.address_latch_control,
      o_boot_window.bus_type} == $past({i_port_zero_pins[10:9],
      i_port_zero_pins[7:6]})) else $error("window zero strap wrong");
   chk_ready_level: assert property (o_cycle_end &&
      i_window_select == 3'h0 && o_boot_window.ready_enable |->
      $past(i_ready) == o_boot_window.ready_polarity)
      else $error("cycle ended without active ready");
   chk_no_ready_end: assert property (i_cycle_start &&
      i_window_select == 3'h0 && !o_boot_window.ready_enable |->
      ##[1:4] o_cycle_end) else $error("cycle without ready hangs");
endmodule
bind system_bus_config_regs sysbus_cfg_chk sysbus_cfg_chk_inst (
   .i_clock, .i_nrst, .i_address, .i_read, .i_write, .o_readdata,
   .o_waitrequest, .o_response, .i_port_zero_pins, .i_byte_high_enable,
   .o_byte_high_enable_pin, .o_byte_high_pin_is_gpio, .i_core_address,
   .o_rom_internal, .o_rom_external, .o_stack_words, .i_cycle_start,
   .i_window_select, .i_ready, .o_cycle_end, .o_boot_window);

// ==== verif/ext_bus_partner.sv ====
// External memory model that answers a bus cycle with the ready line.
// Assumes the ready line is sampled on the system clock.
`timescale 1ns/1ps
module ext_bus_partner (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_cycle_start,
   input wire logic i_cycle_end,
   input wire logic i_polarity,
   input wire logic [7:0] i_delay,
   output logic o_ready
);
   logic busy;
   logic [7:0] count;
   // Counts wait cycles from the start of a cycle; saturates, never wraps
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         busy <= 1'b0;
         count <= 8'h00;
      end else if (i_cycle_start) begin
         busy <= 1'b1;
         count <= 8'h00;
      end else if (i_cycle_end) begin
         busy <= 1'b0;
      end else if (busy && count != 8'hff) begin
         count <= count + 8'h01;
      end
   end
   // Inactive level outside the answer, so an early end is caught
   assign o_ready = (busy && count >= i_delay) ?
      i_polarity : ~i_polarity;
endmodule

// ==== verif/tb_system_bus_config_regs.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the bank answers every Avalon-MM request within a few cycles.
`timescale 1ns/1ps
module tb_system_bus_config_regs;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wd;
      logic [15:0] exp;
      logic [1:0] resp;
   } row_t;
   typedef struct packed {
      logic [15:0] sc;
      logic [23:0] core;
      logic [6:0] pins;
      logic [10:0] stack;
   } cfg_t;
   typedef struct packed {
      logic sel;
      logic [15:0] bw;
      logic pol;
      logic [7:0] dly;
      int mn;
      int mx;
   } rdy_t;
   logic i_clock = 1'b0, i_nrst = 1'b0, i_read = 1'b0, i_write = 1'b0;
   logic [15:0] i_address = 16'h0000, i_port_zero_pins = 16'hffff;
   logic [31:0] i_writedata = 32'h0, o_readdata;
   logic [3:0] i_byteenable = 4'h3;
   logic i_external_access_pin = 1'b1, i_data_bus_8bit = 1'b1;
   logic i_end_of_init_instruction = 1'b0, i_byte_high_enable = 1'b1;
   logic [23:0] i_core_address = 24'h0;
   logic i_cycle_start = 1'b0, i_ready, rpol = 1'b0;
   logic [2:0] i_window_select = 3'h0;
   logic [7:0] rdly = 8'h00;
   logic o_waitrequest, o_system_clock_output_pin, o_clock_pin_is_gpio;
   logic [1:0] o_response;
   logic o_byte_high_enable_pin, o_byte_high_pin_is_gpio, o_rom_internal;
   logic o_rom_external, o_push_code_segment, o_cycle_end;
   logic [10:0] o_stack_words;
   sysbus_cfg_pkg::bus_window_t o_boot_window;
   int n_errors = 0, total_checks = 0;
   row_t rows [9] = '{'{16'hff14, 16'hffff, 16'hf6ff, 2'b00},
      '{16'hff16, 16'ha5a5, 16'ha4a5, 2'b00},
      '{16'hff18, 16'h5a5a, 16'h525a, 2'b00},
      '{16'hff1a, 16'h0f0f, 16'h060f, 2'b00},
      '{16'hff0c, 16'hffff, 16'hf6ff, 2'b00},
      '{16'hff30, 16'h1234, 16'h0000, 2'b10},
      '{16'hff2c, 16'h1234, 16'h1234, 2'b00},
      '{16'hff24, 16'hffff, 16'h0000, 2'b00},
      '{16'hff28, 16'h0000, 16'h0008, 2'b00}};
   cfg_t cfgs [5] = '{'{16'h1d00, 24'h010000, 7'b0010101, 11'h020},
      '{16'ha200, 24'h000000, 7'b1101010, 11'h400},
      '{16'h2400, 24'h007fff, 7'b1011100, 11'h040},
      '{16'h0400, 24'h008000, 7'b1011000, 11'h020},
      '{16'h1400, 24'h000000, 7'b1011000, 11'h020}};
   rdy_t rdys [4] = '{'{1'b0, 16'h1000, 1'b0, 8'd3, 5, 7},
      '{1'b0, 16'h3000, 1'b1, 8'd0, 2, 4},
      '{1'b1, 16'h3000, 1'b1, 8'd4, 6, 8},
      '{1'b0, 16'h0000, 1'b1, 8'd10, 1, 4}};
   logic [31:0] d;
   logic [1:0] r;
   int n;
   // Free-running 25 MHz system clock
   always #20 i_clock = ~i_clock;
   system_bus_config_regs system_bus_config_regs_inst (.i_clock, .i_nrst,
      .i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
      .o_readdata, .o_waitrequest, .o_response, .i_external_access_pin,
      .i_port_zero_pins, .i_data_bus_8bit, .i_end_of_init_instruction,
      .o_system_clock_output_pin, .o_clock_pin_is_gpio, .i_byte_high_enable,
      .o_byte_high_enable_pin, .o_byte_high_pin_is_gpio, .i_core_address,
      .o_rom_internal, .o_rom_external, .o_push_code_segment, .o_stack_words,
      .i_cycle_start, .i_window_select, .i_ready, .o_cycle_end,
      .o_boot_window);
   ext_bus_partner ext_bus_partner_inst (.i_clock, .i_nrst, .i_cycle_start,
      .i_cycle_end(o_cycle_end), .i_polarity(rpol), .i_delay(rdly),
      .o_ready(i_ready));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask
   task stop_test;
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // One Avalon-MM transfer; request held until waitrequest is seen low
   task automatic xfer(input logic rd, input logic [15:0] a,
      input logic [15:0] wd);
      int k;
      @(posedge i_clock);
      i_address <= a;
      i_read <= rd;
      i_write <= !rd;
      i_writedata <= {16'h0000, wd};
      for (k = 0; k < 20; k++) begin
         @(posedge i_clock);
         if (o_waitrequest === 1'b0) break;
      end
      d = o_readdata;
      r = o_response;
      i_read <= 1'b0;
      i_write <= 1'b0;
      if (k == 20) begin
         check(32'h0, 32'h1, "bus timeout");
         stop_test();
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
      xfer(1'b1, a, 16'h0000);
      check(d, {16'h0000, e}, "read");
   endtask
   // Straps are held steady across the whole reset
   task automatic do_reset;
      i_nrst <= 1'b0;
      repeat (4) @(posedge i_clock);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_clock);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Directed scenarios, then the verdict
   initial begin
      do_reset();
      rd_chk(16'hff0c, 16'h06c0);
      for (int i = 0; i < 4; i++) rd_chk(rows[i].addr, 16'h0000);
      rd_chk(16'hff20, 16'h0600);
      foreach (rows[i]) begin
         xfer(1'b0, rows[i].addr, rows[i].wd);
         xfer(1'b1, rows[i].addr, 16'h0000);
         check({30'h0, r}, {30'h0, rows[i].resp}, "response");
         if (rows[i].resp == 2'b00)
            check(d, {16'h0, rows[i].exp}, "row");
      end
      foreach (cfgs[i]) begin
         xfer(1'b0, 16'hff20, cfgs[i].sc);
         @(posedge i_clock) i_core_address <= cfgs[i].core;
         // Looked at just after the edge, while the clock is high
         #1;
         check({25'h0, o_clock_pin_is_gpio, o_byte_high_pin_is_gpio,
            o_byte_high_enable_pin, o_push_code_segment, o_rom_internal,
            o_rom_external, o_system_clock_output_pin},
            {25'h0, cfgs[i].pins},
            "pins");
         check({21'h0, o_stack_words}, {21'h0, cfgs[i].stack},
            "stack");
      end
      // Lock, then a second reset with other straps unlocks again
      @(posedge i_clock) i_end_of_init_instruction <= 1'b1;
      @(posedge i_clock) i_end_of_init_instruction <= 1'b0;
      xfer(1'b0, 16'hff20, 16'hffff);
      rd_chk(16'hff20, 16'h1400);
      i_port_zero_pins <= 16'h0280;
      i_external_access_pin <= 1'b0;
      i_data_bus_8bit <= 1'b0;
      do_reset();
      rd_chk(16'hff0c, 16'h0280);
      rd_chk(16'hff20, 16'h0000);
      xfer(1'b0, 16'hff20, 16'h0100);
      rd_chk(16'hff20, 16'h0100);
      foreach (rdys[i]) begin
         xfer(1'b0, rdys[i].sel ? 16'hff14 : 16'hff0c, rdys[i].bw);
         rpol <= rdys[i].pol;
         rdly <= rdys[i].dly;
         i_window_select <= {2'b00, rdys[i].sel};
         @(posedge i_clock) i_cycle_start <= 1'b1;
         @(posedge i_clock) i_cycle_start <= 1'b0;
         for (n = 1; n < 12; n++) begin
            @(posedge i_clock);
            if (o_cycle_end === 1'b1) break;
         end
         check({31'h0, n >= rdys[i].mn && n <= rdys[i].mx}, 32'h1,
            "ready wait");
      end
      stop_test();
   end
   // Watchdog: a hang counts as a mismatch
   initial begin
      #2000000;
      check(32'h0, 32'h1, "run timeout");
      stop_test();
   end
endmodule
